/* hw/gain_select_decoder.sv */
`timescale 1ns/1ps
`include "link_monitor_params.svh"

// decodes the measured pulldown resistance and latches it once after
// the disable input is released; later changes are ignored
module gain_select_decoder
(
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          gain_sel_valid,
  input  wire logic                          gain_sel_float,
  input  wire logic [15:0]                   gain_sel_ohm,
  output link_monitor_pkg::gain_level_t      gain_level_select,
  output logic                               gain_latched
);
  import link_monitor_pkg::*;

  gain_level_t gain_decoded;
  logic        take_sample;
  gain_level_t gain_r;
  logic        latched_r;

  // between bands the nearer lower level is taken, a documented gap
  assign gain_decoded =
    (gain_sel_float)                           ? 2'd0 :
    (gain_sel_ohm <  16'(`GAIN1_MIN_OHM))      ? 2'd0 :
    (gain_sel_ohm <  16'(`GAIN2_MIN_OHM))      ? 2'd1 :
    (gain_sel_ohm <  16'(`GAIN3_MIN_OHM))      ? 2'd2 :
                                                 2'd3;

  assign take_sample = gain_sel_valid && !latched_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gain_r    <= 2'd0;
      latched_r <= 1'b0;
    end
    else if (take_sample)
    begin
      gain_r    <= gain_decoded;
      latched_r <= 1'b1;
    end
  end

  assign gain_level_select = gain_r;
  assign gain_latched      = latched_r;

  a_gain_frozen : assert property (@(posedge hclk) disable iff (!hresetn)
    $past(latched_r) |-> gain_r == $past(gain_r))
    else $error("gain level changed after latching");

endmodule : gain_select_decoder

/* hw/link_monitor_params.svh */
`ifndef LINK_MONITOR_PARAMS_SVH
`define LINK_MONITOR_PARAMS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_STAT    8'h08
`define OFS_IRQ_MASK    8'h0C
`define OFS_GAIN_CODE   8'h10

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CTRL_SOFT_EN_BIT   0
`define CTRL_RESET         32'h0000_0001
`define IRQ_ATTACH_BIT     0
`define IRQ_DETACH_BIT     1
`define IRQ_HS_UP_BIT      2
`define IRQ_HS_DOWN_BIT    3
`define IRQ_WIDTH          4
`define MASK_RESET         32'h0000_0000

// ---------------------------------------------------------------
// timing, clock 10 MHz
// ---------------------------------------------------------------
`define CLK_MHZ            10
`define CHIRP_MIN_US       18
`define CHIRP_MAX_US       128
`define CHIRP_MIN_CYC      (`CHIRP_MIN_US * `CLK_MHZ)
`define CHIRP_MAX_CYC      (`CHIRP_MAX_US * `CLK_MHZ)

// ---------------------------------------------------------------
// gain select resistance thresholds in ohms
// ---------------------------------------------------------------
`define GAIN0_MAX_OHM      320
`define GAIN1_MIN_OHM      1400
`define GAIN1_MAX_OHM      2200
`define GAIN2_MIN_OHM      3700
`define GAIN2_MAX_OHM      4100
`define GAIN3_MIN_OHM      6000

`endif

/* hw/link_monitor_pkg.sv */
package link_monitor_pkg;

  typedef enum logic [2:0] {
    ST_DETACHED = 3'b000,
    ST_ATTACHED = 3'b001,
    ST_CHIRP_J  = 3'b011,
    ST_CHIRP_K  = 3'b010,
    ST_HS_WAIT  = 3'b110,
    ST_HS       = 3'b111
  } link_state_e;

  typedef enum logic [1:0] {
    SPD_NONE = 2'b00,
    SPD_LS   = 2'b01,
    SPD_FS   = 2'b10,
    SPD_HS   = 2'b11
  } link_speed_e;

  typedef logic [1:0] gain_level_t;

endpackage : link_monitor_pkg

/* hw/usb_hs_link_mode_monitor.sv */
`timescale 1ns/1ps
`include "link_monitor_params.svh"

module usb_hs_link_mode_monitor
#(
  parameter int CHIRP_MIN_CYC = `CHIRP_MIN_CYC,
  parameter int CHIRP_MAX_CYC = `CHIRP_MAX_CYC
)
(
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         device_disable_n,
  input  wire logic                         pullup_dp,
  input  wire logic                         pullup_dm,
  input  wire logic                         disconnect_det,
  input  wire logic                         suspend_det,
  input  wire logic                         chirp_j,
  input  wire logic                         chirp_k,
  input  wire logic                         squelch_det,
  input  wire logic                         gain_sel_valid,
  input  wire logic                         gain_sel_float,
  input  wire logic [15:0]                  gain_sel_ohm,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic                         hready,
  input  wire logic [31:0]                  hwdata,
  output logic [31:0]                       hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic                              attach_flag,
  output logic                              hs_active_flag,
  output logic                              comp_enable,
  output link_monitor_pkg::gain_level_t     comp_level,
  output link_monitor_pkg::link_speed_e     link_speed,
  output logic                              irq
);
  import link_monitor_pkg::*;

  // ---------------------------------------------------------------
  // enable and gain latch
  // ---------------------------------------------------------------
  logic        ctrl_r;
  logic        run;
  logic        run_rst_n;
  gain_level_t gain_level_select;

  // software enable, unlike the pin, does not reset the gain latch, so reenabling relatches nothing
  assign run       = device_disable_n && ctrl_r;
  assign run_rst_n = hresetn && device_disable_n;

  gain_select_decoder u_gain
  (
    .hclk              (hclk),
    .hresetn           (run_rst_n),
    .gain_sel_valid    (gain_sel_valid),
    .gain_sel_float    (gain_sel_float),
    .gain_sel_ohm      (gain_sel_ohm),
    .gain_level_select (gain_level_select),
    .gain_latched      ()
  );

  // ---------------------------------------------------------------
  // mode state machine
  // ---------------------------------------------------------------
  link_state_e state_r;
  link_state_e state_nxt;
  logic [11:0] chirp_cnt_r;
  logic        is_ls_r;
  logic        pullup_any;
  logic        chirp_ok;
  logic        drop_link;

  assign pullup_any = pullup_dp || pullup_dm;
  assign chirp_ok   = (chirp_cnt_r >= 12'(CHIRP_MIN_CYC)) &&
                      (chirp_cnt_r <= 12'(CHIRP_MAX_CYC));
  assign drop_link  = disconnect_det;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_DETACHED:
        if (pullup_any)
          state_nxt = ST_ATTACHED;
      ST_ATTACHED:
        if (drop_link)
          state_nxt = ST_DETACHED;
        else if (chirp_j)
          state_nxt = ST_CHIRP_J;
      ST_CHIRP_J:
        if (drop_link)
          state_nxt = ST_DETACHED;
        else if (chirp_k && chirp_ok)
          state_nxt = ST_CHIRP_K;
        else if (!chirp_j || chirp_cnt_r > 12'(CHIRP_MAX_CYC))
          state_nxt = ST_ATTACHED;
      ST_CHIRP_K:
        if (drop_link)
          state_nxt = ST_DETACHED;
        else if (!chirp_k)
          state_nxt = chirp_ok ? ST_HS_WAIT : ST_ATTACHED;
        else if (chirp_cnt_r > 12'(CHIRP_MAX_CYC))
          state_nxt = ST_ATTACHED;
      ST_HS_WAIT:
        if (drop_link)
          state_nxt = ST_DETACHED;
        else if (squelch_det)
          state_nxt = ST_HS;
      ST_HS:
        if (drop_link)
          state_nxt = ST_DETACHED;
        else if (suspend_det)
          state_nxt = ST_ATTACHED;
      default:
        state_nxt = ST_DETACHED;
    endcase
  end

  logic state_changed;
  assign state_changed = state_nxt != state_r;

  // disable resets the tracker, so flags stay low until detection
  always_ff @(posedge hclk or negedge run_rst_n)
  begin
    if (!run_rst_n)
      state_r <= ST_DETACHED;
    else if (!ctrl_r)
      state_r <= ST_DETACHED;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge hclk or negedge run_rst_n)
  begin
    if (!run_rst_n)
      chirp_cnt_r <= 12'h000;
    else if (state_changed)
      chirp_cnt_r <= 12'h001;
    else if (chirp_cnt_r != 12'hFFF)
      chirp_cnt_r <= chirp_cnt_r + 12'h001;
  end

  // which line pulled up at attach tells low from full speed
  always_ff @(posedge hclk or negedge run_rst_n)
  begin
    if (!run_rst_n)
      is_ls_r <= 1'b0;
    else if (state_r == ST_DETACHED && pullup_any)
      is_ls_r <= pullup_dm && !pullup_dp;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic attached;
  logic in_hs;
  assign attached = state_r != ST_DETACHED;
  assign in_hs    = state_r == ST_HS;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      attach_flag    <= 1'b0;
      hs_active_flag <= 1'b0;
      comp_enable    <= 1'b0;
      comp_level     <= 2'd0;
      link_speed     <= SPD_NONE;
    end
    else
    begin
      attach_flag    <= run && attached;
      hs_active_flag <= run && in_hs;
      comp_enable    <= run && in_hs;
      comp_level     <= gain_level_select;
      link_speed     <= !(run && attached) ? SPD_NONE :
                        in_hs ? SPD_HS : is_ls_r ? SPD_LS : SPD_FS;
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  logic                 wr_pend_r;
  logic [7:0]           addr_r;
  logic [`IRQ_WIDTH-1:0] irq_stat_r;
  logic [`IRQ_WIDTH-1:0] irq_mask_r;
  logic                 addr_phase;
  logic [`IRQ_WIDTH-1:0] events;
  logic [`IRQ_WIDTH-1:0] w1c;
  logic [31:0]          rd_word;
  logic [7:0]           rd_addr;

  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  // read data is decoded in the address phase so that it stands in a zero-wait data phase
  assign rd_addr    = haddr[7:0];

  assign events[`IRQ_ATTACH_BIT]  = attach_flag == 1'b0 && run && attached;
  assign events[`IRQ_DETACH_BIT]  = attach_flag && !(run && attached);
  assign events[`IRQ_HS_UP_BIT]   = !hs_active_flag && run && in_hs;
  assign events[`IRQ_HS_DOWN_BIT] = hs_active_flag && !(run && in_hs);
  assign w1c = (wr_pend_r && addr_r == `OFS_IRQ_STAT) ?
               hwdata[`IRQ_WIDTH-1:0] : '0;

  assign rd_word =
    (rd_addr == `OFS_CTRL)      ? {31'h0, ctrl_r} :
    (rd_addr == `OFS_STATUS)    ? {26'h0, link_speed, comp_enable,
                                   hs_active_flag, attach_flag, device_disable_n} :
    (rd_addr == `OFS_IRQ_STAT)  ? {28'h0, irq_stat_r} :
    (rd_addr == `OFS_IRQ_MASK)  ? {28'h0, irq_mask_r} :
    (rd_addr == `OFS_GAIN_CODE) ? {30'h0, gain_level_select} :
                                 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= addr_phase && hwrite;
      if (addr_phase)
        addr_r <= haddr[7:0];
      if (addr_phase && !hwrite)
        hrdata <= rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r     <= 1'b1;
      irq_mask_r <= '0;
      irq_stat_r <= '0;
    end
    else
    begin
      if (wr_pend_r && addr_r == `OFS_CTRL)
        ctrl_r <= hwdata[`CTRL_SOFT_EN_BIT];
      if (wr_pend_r && addr_r == `OFS_IRQ_MASK)
        irq_mask_r <= hwdata[`IRQ_WIDTH-1:0];
      // set wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~w1c) | events;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_chirp_pair;
    state_r == ST_CHIRP_K ##1 state_r == ST_HS_WAIT;
  endsequence

  sequence s_chirp_j_to_k;
    state_r == ST_CHIRP_J ##1 state_r == ST_CHIRP_K;
  endsequence

  a_disable_quiet : assert property (@(posedge hclk) disable iff (!hresetn)
    !device_disable_n |=> !attach_flag && !hs_active_flag && !comp_enable)
    else $error("flags or compensation active while disabled");

  a_disable_resets : assert property (@(posedge hclk) disable iff (!hresetn)
    !device_disable_n |-> state_r == ST_DETACHED)
    else $error("state not cleared while disabled");

  a_hs_needs_attach : assert property (@(posedge hclk) disable iff (!hresetn)
    hs_active_flag |-> attach_flag)
    else $error("hs flag without attach flag");

  a_comp_only_hs : assert property (@(posedge hclk) disable iff (!hresetn)
    comp_enable == hs_active_flag)
    else $error("compensation outside high speed");

  a_comp_level : assert property (@(posedge hclk) disable iff (!hresetn)
    comp_enable |-> comp_level == $past(gain_level_select))
    else $error("compensation level mismatch");

  a_attach_rise : assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == ST_DETACHED && pullup_any && run |=> ##1 attach_flag)
    else $error("attach flag not raised after pull-up");

  a_hs_drop : assert property (@(posedge hclk) disable iff (!hresetn)
    in_hs && (disconnect_det || suspend_det) |=> ##1 !hs_active_flag)
    else $error("hs flag not lowered on disconnect or suspend");

  a_hs_after_pair : assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(state_r == ST_HS) |-> $past(state_r) == ST_HS_WAIT)
    else $error("high speed entered without handshake");

  a_pair_timed : assert property (@(posedge hclk) disable iff (!hresetn)
    s_chirp_pair |-> $past(chirp_cnt_r) >= 12'(CHIRP_MIN_CYC))
    else $error("chirp k too short");

  a_ls_fs_attach : assert property (@(posedge hclk) disable iff (!hresetn)
    link_speed == SPD_LS || link_speed == SPD_FS |-> attach_flag && !comp_enable)
    else $error("low or full speed status wrong");

  a_flags_low_init : assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(device_disable_n) |=> !attach_flag)
    else $error("flag raised too early after enable");

  a_pair_k_max : assert property (@(posedge hclk) disable iff (!hresetn)
    s_chirp_pair |-> $past(chirp_cnt_r) <= 12'(CHIRP_MAX_CYC))
    else $error("chirp k too long");

  a_pair_j_min : assert property (@(posedge hclk) disable iff (!hresetn)
    s_chirp_j_to_k |-> $past(chirp_cnt_r) >= 12'(CHIRP_MIN_CYC))
    else $error("chirp j too short");

  a_attach_drop : assert property (@(posedge hclk) disable iff (!hresetn)
    attached && disconnect_det |=> ##1 !attach_flag)
    else $error("attach flag not lowered on disconnect");

  a_hs_speed : assert property (@(posedge hclk) disable iff (!hresetn)
    hs_active_flag |-> link_speed == SPD_HS)
    else $error("hs flag without high speed status");

  a_plain_no_comp : assert property (@(posedge hclk) disable iff (!hresetn)
    link_speed != SPD_HS |-> !comp_enable)
    else $error("compensation outside high speed status");

  a_attach_event : assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(attach_flag) |-> irq_stat_r[`IRQ_ATTACH_BIT])
    else $error("attach event not recorded");

endmodule : usb_hs_link_mode_monitor

/* sim/usb_far_end.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// far side of the channel: host and peripheral line events
// ---------------------------------------------------------------
module usb_far_end
(
  input  wire logic hclk,
  output logic      pullup_dp,
  output logic      pullup_dm,
  output logic      disconnect_det,
  output logic      suspend_det,
  output logic      chirp_j,
  output logic      chirp_k,
  output logic      squelch_det
);
  initial
  begin
    {pullup_dp, pullup_dm, disconnect_det, suspend_det} = 4'h0;
    {chirp_j, chirp_k, squelch_det} = 3'h0;
  end

  // low speed parts pull up d-, full and high speed parts d+
  task plug(input logic low_speed);
    @(posedge hclk);
    pullup_dp <= !low_speed;
    pullup_dm <= low_speed;
  endtask : plug

  // chirp lengths are free so that a short, failing chirp can be sent
  task chirp(input int jn, input int kn);
    @(posedge hclk);
    chirp_j <= 1'b1;
    repeat (jn) @(posedge hclk);
    chirp_j <= 1'b0;
    chirp_k <= 1'b1;
    repeat (kn) @(posedge hclk);
    chirp_k <= 1'b0;
    @(posedge hclk);
    squelch_det <= 1'b1;
    repeat (2) @(posedge hclk);
    squelch_det <= 1'b0;
  endtask : chirp

  task unplug;
    @(posedge hclk);
    {pullup_dp, pullup_dm} <= 2'b00;
    disconnect_det <= 1'b1;
    repeat (2) @(posedge hclk);
    disconnect_det <= 1'b0;
  endtask : unplug

  task suspend;
    @(posedge hclk);
    suspend_det <= 1'b1;
    repeat (2) @(posedge hclk);
    suspend_det <= 1'b0;
  endtask : suspend
endmodule : usb_far_end

/* sim/usb_hs_link_mode_monitor_test.sv */
`timescale 1ns/1ps
`include "link_monitor_params.svh"

module usb_hs_link_mode_monitor_test;
  import link_monitor_pkg::*;
  logic        hclk, hresetn, device_disable_n, gain_sel_valid, gain_sel_float;
  logic [15:0] gain_sel_ohm;
  logic        hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hready, pullup_dp, pullup_dm, disconnect_det, suspend_det;
  wire logic   chirp_j, chirp_k, squelch_det;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, attach_flag, hs_active_flag, comp_enable, irq;
  gain_level_t comp_level;
  link_speed_e link_speed;
  int          n_checks, n_mismatch;

  assign hready = hreadyout;

  usb_far_end far
  (
    .hclk           (hclk),
    .pullup_dp      (pullup_dp),
    .pullup_dm      (pullup_dm),
    .disconnect_det (disconnect_det),
    .suspend_det    (suspend_det),
    .chirp_j        (chirp_j),
    .chirp_k        (chirp_k),
    .squelch_det    (squelch_det)
  );

  usb_hs_link_mode_monitor
  #(
    .CHIRP_MIN_CYC (`CHIRP_MIN_CYC),
    .CHIRP_MAX_CYC (`CHIRP_MAX_CYC)
  )
  dut
  (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .device_disable_n (device_disable_n),
    .pullup_dp        (pullup_dp),
    .pullup_dm        (pullup_dm),
    .disconnect_det   (disconnect_det),
    .suspend_det      (suspend_det),
    .chirp_j          (chirp_j),
    .chirp_k          (chirp_k),
    .squelch_det      (squelch_det),
    .gain_sel_valid   (gain_sel_valid),
    .gain_sel_float   (gain_sel_float),
    .gain_sel_ohm     (gain_sel_ohm),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hready           (hready),
    .hwdata           (hwdata),
    .hrdata           (hrdata),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .attach_flag      (attach_flag),
    .hs_active_flag   (hs_active_flag),
    .comp_enable      (comp_enable),
    .comp_level       (comp_level),
    .link_speed       (link_speed),
    .irq              (irq)
  );

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // ends one edge after the data phase so combinational irq has settled
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    @(posedge hclk);
  endtask : ahb

  task rd(input logic [31:0] a, output logic [31:0] v);
    ahb(1'b0, a, 32'h0000_0000, v);
  endtask : rd

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, a, d, dummy);
  endtask : wr

  task wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : wait_cyc

  task go_hs;
    far.plug(1'b0);
    wait_cyc(4);
    far.chirp(`CHIRP_MIN_CYC, `CHIRP_MAX_CYC);
    wait_cyc(3);
  endtask : go_hs

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    logic [31:0] v;
    rd(`OFS_CTRL, v);
    chk("ctrl", `CTRL_RESET, v);
    chk("hresp", 0, hresp);
    wr(`OFS_CTRL, 32'h0000_0000);
    rd(`OFS_CTRL, v);
    chk("ctrl off", 32'h0000_0000, v);
    wr(`OFS_CTRL, `CTRL_RESET);
    rd(`OFS_IRQ_MASK, v);
    chk("irq_mask", `MASK_RESET, v);
    wr(32'h0000_0040, 32'hFFFF_FFFF);
    rd(32'h0000_0040, v);
    chk("unmapped", 32'h0000_0000, v);
    $display("test regs done");
  endtask : t_regs

  task t_gain;
    logic [31:0] v;
    int          ohm [10] = '{100, 320, 1000, 1400, 2200, 2900, 3700, 4100, 5000, 6000};
    int          lvl [10] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 3};
    for (int i = 0; i < 10; i++)
    begin
      gain_sel_ohm     <= 16'(ohm[i]);
      device_disable_n <= 1'b0;
      wait_cyc(2);
      device_disable_n <= 1'b1;
      wait_cyc(3);
      rd(`OFS_GAIN_CODE, v);
      chk("gain_code", 32'(lvl[i]), v);
    end
    $display("test gain done");
  endtask : t_gain

  task t_ls;
    logic [31:0] v;
    far.plug(1'b1);
    wait_cyc(4);
    chk("attach ls", 1, attach_flag);
    chk("comp ls", 0, comp_enable);
    chk("speed ls", SPD_LS, link_speed);
    chk("irq masked", 0, irq);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    chk("irq on", 1, irq);
    wr(`OFS_IRQ_STAT, 32'h0000_0001);
    chk("irq cleared", 0, irq);
    far.unplug();
    wait_cyc(4);
    chk("attach off", 0, attach_flag);
    rd(`OFS_IRQ_STAT, v);
    chk("irq_stat", 32'h0000_0002, v);
    chk("irq detach masked", 0, irq);
    wr(`OFS_IRQ_STAT, 32'h0000_000F);
    $display("test ls done");
  endtask : t_ls

  task t_fs_short;
    far.plug(1'b0);
    wait_cyc(4);
    chk("attach fs", 1, attach_flag);
    chk("speed fs", SPD_FS, link_speed);
    chk("comp fs", 0, comp_enable);
    far.chirp(5, 20);
    wait_cyc(4);
    chk("hs short chirp", 0, hs_active_flag);
    far.chirp(`CHIRP_MIN_CYC, `CHIRP_MAX_CYC + 1);
    wait_cyc(4);
    chk("hs long chirp", 0, hs_active_flag);
    far.unplug();
    wait_cyc(4);
    $display("test short chirp done");
  endtask : t_fs_short

  task t_hs;
    logic [31:0] v;
    gain_sel_ohm <= 16'h0064;
    go_hs();
    chk("hs flag", 1, hs_active_flag);
    chk("attach hs", 1, attach_flag);
    chk("comp hs", 1, comp_enable);
    chk("level hs", 3, comp_level);
    rd(`OFS_STATUS, v);
    chk("status hs", 32'h0000_003F, v);
    far.suspend();
    wait_cyc(4);
    chk("hs suspend", 0, hs_active_flag);
    chk("attach suspend", 1, attach_flag);
    far.chirp(`CHIRP_MAX_CYC, `CHIRP_MIN_CYC);
    wait_cyc(3);
    chk("hs again", 1, hs_active_flag);
    far.unplug();
    wait_cyc(4);
    chk("hs unplug", 0, hs_active_flag);
    chk("attach unplug", 0, attach_flag);
    $display("test hs done");
  endtask : t_hs

  task t_disable;
    gain_sel_float <= 1'b1;
    go_hs();
    device_disable_n <= 1'b0;
    wait_cyc(3);
    chk("attach dis", 0, attach_flag);
    chk("hs dis", 0, hs_active_flag);
    chk("comp dis", 0, comp_enable);
    far.unplug();
    device_disable_n <= 1'b1;
    wait_cyc(6);
    chk("attach idle", 0, attach_flag);
    chk("hs idle", 0, hs_active_flag);
    go_hs();
    chk("hs float", 1, hs_active_flag);
    chk("level float", 0, comp_level);
    far.unplug();
    $display("test disable done");
  endtask : t_disable

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    {hresetn, hsel, hwrite, gain_sel_float} = 4'h0;
    {device_disable_n, gain_sel_valid} = 2'b11;
    gain_sel_ohm = 16'h0F3C;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'b00;
    hsize = 3'b010;
    wait_cyc(2);
    hresetn <= 1'b1;
    wait_cyc(1);
    t_regs();
    t_gain();
    t_ls();
    t_fs_short();
    t_hs();
    t_disable();
    conclude();
  end

  initial
  begin
    wait_cyc(20000);
    n_mismatch++;
    $display("watchdog expired");
    conclude();
  end
endmodule : usb_hs_link_mode_monitor_test
